// [verilog/uart_de_defs.vh]
// Register offsets, field positions, reset values and timing counts.
// Included by the serial block and its infrared decoder.
`ifndef UART_DE_DEFS_VH
`define UART_DE_DEFS_VH
`define UART_TXD_OFS 12'h000
`define UART_RXD_OFS 12'h004
`define UART_STAT_OFS 12'h008
`define UART_CTL0_OFS 12'h00C
`define UART_CTL1_OFS 12'h010
`define UART_BRG_OFS 12'h014
`define CTL0_TEN 0
`define CTL0_REN 1
`define CTL0_PEN 2
`define CTL0_PSEL 3
`define CTL0_STOP2 4
`define CTL1_TRANSCEIVER_ENABLE_POLARITY 0
`define CTL1_IREN 1
`define CTL1_MPEN 2
`define CTL1_MPBT 3
`define STAT_RDA 0
`define STAT_PE 1
`define STAT_FE 2
`define STAT_OE 3
`define STAT_TDRE 4
`define STAT_TXE 5
`define STAT_NEW_FRAME_FLAG 6
`define STAT_MPRX 7
`define STAT_TMR 8
`define BRG_RESET 16'h0001
`define IR_SAMPLE_CNT 4'h8
`define IR_WINDOW_CNT 4'hC
`define IR_LAST_CNT 4'hF
`endif

// [verilog/ir_rx_decoder.v]
// Infrared pulse decoder feeding the serial receiver.
// Assumes a one-cycle baud tick at sixteen times the bit rate and a
// pulse input already synchronised to pclk.
`timescale 1ns/10ps
`include "uart_de_defs.vh"
module ir_rx_decoder (
   input wire pclk,
   input wire presetn,
   input wire enable,
   input wire baud_tick,
   input wire pulse_in,
   output reg rxd_out
);
   reg [3:0] cnt_q;
   reg prev_q;
   reg seen_q;
   reg win_q;
   wire fall;

   // A falling pulse edge marks the start of a bit cell.
   assign fall = prev_q & ~pulse_in;

   // Counter restarts on a pulse that falls while the window is open, updates the output at eight and
   // reopens the window at twelve.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 4'h0;
         prev_q <= 1'b1;
         seen_q <= 1'b0;
         win_q <= 1'b1;
         rxd_out <= 1'b1;
      end else if (!enable) begin
         cnt_q <= 4'h0;
         prev_q <= 1'b1;
         seen_q <= 1'b0;
         win_q <= 1'b1;
         rxd_out <= 1'b1;
      end else begin
         prev_q <= pulse_in;
         if (fall && win_q) begin
            cnt_q <= 4'h0;
            seen_q <= 1'b1;
            win_q <= 1'b0;
         end else if (baud_tick) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == `IR_SAMPLE_CNT) begin
               rxd_out <= ~seen_q;
               seen_q <= 1'b0;
            end
            if (cnt_q == `IR_WINDOW_CNT) begin
               win_q <= 1'b1;
            end
         end
      end
   end
endmodule // ir_rx_decoder

// [verilog/uart_de.v]
// Serial transmitter and receiver with transceiver enable and infrared
// receive decoding, registers on APB.
// Assumes pclk at 100 MHz and pins from outside the pclk domain.
//
// Summary of operation
// - Eight data bits, least significant first.
// - Optional even or odd parity, checked.
// - Low start bit, one or two stops.
// - Multiprocessor mode: no interrupt on address.
// - New-frame flag with first data byte.
// - Enable covers whole transmitted frame.
// - Enable asserts on transmit data write.
// - Start bit one to two bits later.
// - Enable drops one clock after stop.
// - Back-to-back characters keep enable high.
// - Polarity bit selects enable level.
// - Separate transmit and receive interrupts.
// - Baud generator as timer when disabled.
// - Decoder timed by baud clock, feeds receiver.
// - Infrared bit is sixteen baud clocks.
// - Receive pin carries pulses in infrared mode.
// - Decoder counter 0..15, reset on fall.
// - Decoded stream lags by nine baud clocks.
// - Decoded value updated at count eight.
// - Sampling window opens at count twelve.
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/10ps
`include "uart_de_defs.vh"
module uart_de (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire rxd_pin,
   output reg txd_out,
   output wire transceiver_enable_out,
   output wire tx_irq,
   output wire rx_irq
);
   localparam TX_IDLE = 3'd0;
   localparam TX_SETUP = 3'd1;
   localparam TX_START = 3'd2;
   localparam TX_DATA = 3'd3;
   localparam TX_PAR = 3'd4;
   localparam TX_STOP = 3'd5;
   localparam TX_TAIL = 3'd6;
   localparam RX_IDLE = 3'd0;
   localparam RX_START = 3'd1;
   localparam RX_DATA = 3'd2;
   localparam RX_PAR = 3'd3;
   localparam RX_STOP = 3'd4;

   reg [7:0] ctl0_q;
   reg [7:0] ctl1_q;
   reg [15:0] brg_q;
   reg [15:0] brg_cnt_q;
   reg tick_q;
   reg rx_s1_q;
   reg rx_s2_q;
   reg [7:0] tdr_q;
   reg tdr_full_q;
   reg [2:0] tx_st_q;
   reg [3:0] tx_sub_q;
   reg [2:0] tx_bit_q;
   reg [7:0] tx_sh_q;
   reg tx_stop_q;
   reg tx_par_q;
   reg de_q;
   reg [2:0] rx_st_q;
   reg [3:0] rx_sub_q;
   reg [2:0] rx_bit_q;
   reg [7:0] rx_sh_q;
   reg rx_par_q;
   reg [7:0] rdr_q;
   reg rda_q;
   reg pe_q;
   reg fe_q;
   reg oe_q;
   reg new_frame_flag_q;
   reg mprx_q;
   reg tmr_q;
   reg rx_prev_q;
   wire infrared_pulse_input;
   wire rx_line;
   wire wr;
   wire rd;
   wire uart_on;
   wire rx_done;
   wire rx_addr;
   wire rx_err;

   // Parity over a byte, odd selection inverts even parity.
   function par_of;
      input [7:0] d;
      input odd;
      begin
         par_of = ^d ^ odd;
      end
   endfunction

   assign wr = psel & penable & pwrite;
   assign rd = psel & penable & ~pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign uart_on = ctl0_q[`CTL0_TEN] | ctl0_q[`CTL0_REN];

   // Two-flop synchroniser for the receive pin.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_s1_q <= 1'b1;
         rx_s2_q <= 1'b1;
      end else begin
         rx_s1_q <= rxd_pin;
         rx_s2_q <= rx_s1_q;
      end
   end

   // Baud generator gives one tick per reload; each bit is sixteen
   // ticks, and with the serial function off it acts as a timer.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brg_cnt_q <= 16'h0000;
         tick_q <= 1'b0;
      end else if (brg_cnt_q == 16'h0000) begin
         brg_cnt_q <= brg_q - 16'h0001;
         tick_q <= 1'b1;
      end else begin
         brg_cnt_q <= brg_cnt_q - 16'h0001;
         tick_q <= 1'b0;
      end
   end

   ir_rx_decoder u_ir_rx_decoder (
      .pclk(pclk),
      .presetn(presetn),
      .enable(ctl1_q[`CTL1_IREN]),
      .baud_tick(tick_q),
      .pulse_in(rx_s2_q),
      .rxd_out(infrared_pulse_input)
   );

   // In infrared mode the pin carries pulses and the receiver sees
   // the decoded stream instead.
   assign rx_line = ctl1_q[`CTL1_IREN] ? infrared_pulse_input : rx_s2_q;

   // Control register writes.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl0_q <= 8'h00;
         ctl1_q <= 8'h00;
         brg_q <= `BRG_RESET;
      end else if (wr) begin
         if (paddr == `UART_CTL0_OFS) begin
            ctl0_q <= pwdata[7:0];
         end
         if (paddr == `UART_CTL1_OFS) begin
            ctl1_q <= pwdata[7:0];
         end
         if (paddr == `UART_BRG_OFS) begin
            brg_q <= (pwdata[15:0] == 16'h0000) ? `BRG_RESET : pwdata[15:0];
         end
      end
   end

   // Transmitter: enable rises on the data write, then a full bit of
   // setup before the start bit, held through stops plus one clock.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tdr_q <= 8'h00;
         tdr_full_q <= 1'b0;
         tx_st_q <= TX_IDLE;
         tx_sub_q <= 4'h0;
         tx_bit_q <= 3'd0;
         tx_sh_q <= 8'h00;
         tx_stop_q <= 1'b0;
         tx_par_q <= 1'b0;
         txd_out <= 1'b1;
         de_q <= 1'b0;
      end else begin
         if (wr && paddr == `UART_TXD_OFS) begin
            tdr_q <= pwdata[7:0];
            tdr_full_q <= 1'b1;
         end
         case (tx_st_q)
            TX_IDLE: begin
               txd_out <= 1'b1;
               if (tdr_full_q && ctl0_q[`CTL0_TEN]) begin
                  de_q <= 1'b1;
                  tx_st_q <= TX_SETUP;
                  tx_sub_q <= 4'h0;
               end
            end
            TX_SETUP: begin
               if (tick_q) begin
                  tx_sub_q <= tx_sub_q + 4'h1;
                  if (tx_sub_q == 4'hF) begin
                     tx_st_q <= TX_START;
                  end
               end
            end
            TX_START: begin
               txd_out <= 1'b0;
               if (tick_q && tx_sub_q == 4'h0) begin
                  tx_sh_q <= tdr_q;
                  tx_par_q <= par_of(tdr_q, ctl0_q[`CTL0_PSEL]);
                  tdr_full_q <= wr && paddr == `UART_TXD_OFS;
               end
               if (tick_q) begin
                  tx_sub_q <= tx_sub_q + 4'h1;
                  if (tx_sub_q == 4'hF) begin
                     tx_st_q <= TX_DATA;
                     tx_bit_q <= 3'd0;
                  end
               end
            end
            TX_DATA: begin
               txd_out <= tx_sh_q[0];
               if (tick_q) begin
                  tx_sub_q <= tx_sub_q + 4'h1;
                  if (tx_sub_q == 4'hF) begin
                     tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                     tx_bit_q <= tx_bit_q + 3'd1;
                     if (tx_bit_q == 3'd7) begin
                        tx_st_q <= ctl0_q[`CTL0_PEN] ? TX_PAR : TX_STOP;
                        tx_stop_q <= 1'b0;
                     end
                  end
               end
            end
            TX_PAR: begin
               txd_out <= ctl1_q[`CTL1_MPEN] ? ctl1_q[`CTL1_MPBT] : tx_par_q;
               if (tick_q) begin
                  tx_sub_q <= tx_sub_q + 4'h1;
                  if (tx_sub_q == 4'hF) begin
                     tx_st_q <= TX_STOP;
                  end
               end
            end
            TX_STOP: begin
               txd_out <= 1'b1;
               if (tick_q) begin
                  tx_sub_q <= tx_sub_q + 4'h1;
                  if (tx_sub_q == 4'hF) begin
                     if (ctl0_q[`CTL0_STOP2] && !tx_stop_q) begin
                        tx_stop_q <= 1'b1;
                     end else if (tdr_full_q) begin
                        tx_st_q <= TX_START;
                     end else begin
                        tx_st_q <= TX_TAIL;
                     end
                  end
               end
            end
            TX_TAIL: begin
               // The stop bit leaves the pin a clock after its last tick,
               // so the enable waits one clock more before it drops.
               if (tdr_full_q) begin
                  tx_st_q <= TX_SETUP;
                  tx_sub_q <= 4'h0;
               end else if (tx_sub_q == 4'h0) begin
                  tx_sub_q <= 4'h1;
               end else begin
                  de_q <= 1'b0;
                  tx_st_q <= TX_IDLE;
               end
            end
            default: begin
               tx_st_q <= TX_IDLE;
               de_q <= 1'b0;
            end
         endcase
      end
   end

   assign transceiver_enable_out = de_q ^ ctl1_q[`CTL1_TRANSCEIVER_ENABLE_POLARITY];

   // Receiver completion at mid stop bit, so that a start bit following
   // at once is not taken for a framing error.
   assign rx_done = rx_st_q == RX_STOP && tick_q && rx_sub_q == 4'h7;
   assign rx_addr = ctl1_q[`CTL1_MPEN] & rx_par_q;
   assign rx_err = ~rx_line;

   // Receiver: samples mid-bit, sixteen ticks per bit.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_st_q <= RX_IDLE;
         rx_sub_q <= 4'h0;
         rx_bit_q <= 3'd0;
         rx_sh_q <= 8'h00;
         rx_par_q <= 1'b0;
         rx_prev_q <= 1'b1;
      end else begin
         rx_prev_q <= rx_line;
         case (rx_st_q)
            RX_IDLE: begin
               if (ctl0_q[`CTL0_REN] && rx_prev_q && !rx_line) begin
                  rx_st_q <= RX_START;
                  rx_sub_q <= 4'h0;
               end
            end
            RX_START: begin
               if (tick_q) begin
                  rx_sub_q <= rx_sub_q + 4'h1;
                  if (rx_sub_q == 4'h7 && rx_line) begin
                     rx_st_q <= RX_IDLE;
                  end
                  if (rx_sub_q == 4'hF) begin
                     rx_st_q <= RX_DATA;
                     rx_bit_q <= 3'd0;
                  end
               end
            end
            RX_DATA: begin
               if (tick_q) begin
                  rx_sub_q <= rx_sub_q + 4'h1;
                  if (rx_sub_q == 4'h7) begin
                     rx_sh_q <= {rx_line, rx_sh_q[7:1]};
                  end
                  if (rx_sub_q == 4'hF) begin
                     rx_bit_q <= rx_bit_q + 3'd1;
                     if (rx_bit_q == 3'd7) begin
                        rx_st_q <= ctl0_q[`CTL0_PEN] ? RX_PAR : RX_STOP;
                        rx_par_q <= 1'b0;
                     end
                  end
               end
            end
            RX_PAR: begin
               if (tick_q) begin
                  rx_sub_q <= rx_sub_q + 4'h1;
                  if (rx_sub_q == 4'h7) begin
                     rx_par_q <= rx_line;
                  end
                  if (rx_sub_q == 4'hF) begin
                     rx_st_q <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (tick_q) begin
                  rx_sub_q <= rx_sub_q + 4'h1;
                  if (rx_sub_q == 4'h7) begin
                     rx_st_q <= RX_IDLE;
                  end
               end
            end
            default: rx_st_q <= RX_IDLE;
         endcase
      end
   end

   // Receive status; hardware set wins over a clearing read.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdr_q <= 8'h00;
         rda_q <= 1'b0;
         pe_q <= 1'b0;
         fe_q <= 1'b0;
         oe_q <= 1'b0;
         new_frame_flag_q <= 1'b0;
         mprx_q <= 1'b0;
         tmr_q <= 1'b0;
      end else begin
         if (rd && paddr == `UART_RXD_OFS) begin
            rda_q <= 1'b0;
            pe_q <= 1'b0;
            fe_q <= 1'b0;
            oe_q <= 1'b0;
            new_frame_flag_q <= 1'b0;
         end
         if (rd && paddr == `UART_STAT_OFS) begin
            tmr_q <= 1'b0;
         end
         if (!uart_on && tick_q) begin
            tmr_q <= 1'b1;
         end
         if (rx_done && rx_addr) begin
            mprx_q <= 1'b1;
         end else if (rx_done) begin
            rdr_q <= rx_sh_q;
            rda_q <= 1'b1;
            oe_q <= rda_q;
            fe_q <= rx_err;
            pe_q <= ctl0_q[`CTL0_PEN] & ~ctl1_q[`CTL1_MPEN] &
               (rx_par_q != par_of(rx_sh_q, ctl0_q[`CTL0_PSEL]));
            if (mprx_q) begin
               new_frame_flag_q <= 1'b1;
               mprx_q <= 1'b0;
            end
         end
      end
   end

   // Independent interrupt requests; address bytes raise none.
   assign rx_irq = ctl0_q[`CTL0_REN] & rda_q;
   assign tx_irq = (ctl0_q[`CTL0_TEN] & ~tdr_full_q) | tmr_q;

   // Read data mux, unmapped reads return zero.
   always @* begin
      case (paddr)
         `UART_RXD_OFS: prdata = {24'h000000, rdr_q};
         `UART_STAT_OFS: prdata = {23'h000000, tmr_q, mprx_q, new_frame_flag_q,
            (tx_st_q == TX_IDLE), ~tdr_full_q, oe_q, fe_q, pe_q, rda_q};
         `UART_CTL0_OFS: prdata = {24'h000000, ctl0_q};
         `UART_CTL1_OFS: prdata = {24'h000000, ctl1_q};
         `UART_BRG_OFS: prdata = {16'h0000, brg_q};
         default: prdata = 32'h00000000;
      endcase
   end
endmodule // uart_de

// [verif/uart_de_asserts.sv]
// Port-level checks for the serial block with transceiver enable.
// Assumes the baud reload stays 1 while characters are being sent.
`timescale 1ns/10ps
module uart_de_asserts (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire txd_out,
   input wire transceiver_enable_out,
   input wire rx_irq
);
   logic pol_q;
   logic ten_q;
   wire wr = psel && penable && pwrite;
   wire de_act = transceiver_enable_out ^ pol_q;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Tracks polarity and transmit enable as software writes them.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pol_q <= 1'b0;
         ten_q <= 1'b0;
      end else if (wr && paddr == 12'h010) begin
         pol_q <= pwdata[0];
      end else if (wr && paddr == 12'h00C) begin
         ten_q <= pwdata[0];
      end
   end
   a_apb_ready: assert property (psel |-> pready && !pslverr)
      else $error("bus answer not ready or in error");
   a_unmapped_zero: assert property (
      psel && !pwrite && paddr > 12'h014 |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_de_on_write: assert property (
      wr && paddr == 12'h000 && ten_q |-> ##2 de_act)
      else $error("enable late after data write");
   a_idle_high: assert property (!de_act |-> txd_out)
      else $error("line driven outside the enable");
   a_start_late: assert property (
      $rose(de_act) |-> ##[15:33] !txd_out)
      else $error("start bit too late");
   a_start_early: assert property (
      $fell(txd_out) |-> $past(de_act, 16))
      else $error("start bit too early");
   a_de_tail: assert property (
      $fell(de_act) |-> $past(txd_out, 1) && $past(txd_out, 16))
      else $error("enable dropped before the stop ended");
   a_rx_clear: assert property (
      psel && penable && !pwrite && paddr == 12'h004 |=> !rx_irq)
      else $error("receive request stays after read");
endmodule // uart_de_asserts

// [verif/line_end.sv]
// Off-chip line and infrared transceiver model.
// Assumes one bit lasts BIT pclk cycles; the line idles high.
`timescale 1ns/10ps
module line_end #(parameter int BIT = 16) (
   input wire pclk,
   input wire txd,
   output logic rxd
);
   initial rxd = 1'b1;
   // Sends n frame bits, least significant first, plain or as pulses.
   task automatic send(input logic [11:0] fr, input int n, input bit ir);
      for (int i = 0; i < n; i++) begin
         for (int c = 0; c < BIT; c++) begin
            @(posedge pclk);
            rxd <= ir ? (fr[i] | c > 2) : fr[i];
         end
      end
      @(posedge pclk);
      rxd <= 1'b1;
   endtask
   // Samples n bits of the next frame at mid-bit; unused bits read 1.
   task automatic grab(input int n, output logic [11:0] fr);
      int t;
      fr = 12'hFFF;
      t = 0;
      while (txd !== 1'b0 && t < 2000) begin
         @(posedge pclk);
         t++;
      end
      repeat (BIT / 2) @(posedge pclk);
      for (int i = 0; i < n; i++) begin
         fr[i] = txd;
         if (i < n - 1) repeat (BIT) @(posedge pclk);
      end
   endtask
endmodule // line_end

// [verif/uart_de_test.sv]
// Self-checking bench for the serial block with transceiver enable.
// Assumes the line model on the pins and the checker bound below.
`timescale 1ns/10ps
module uart_de_test;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   wire [31:0] prdata;
   wire pready;
   wire pslverr;
   wire rxd_pin;
   wire txd_out;
   wire transceiver_enable_out;
   wire tx_irq;
   wire rx_irq;
   logic pol = 1'b0;
   wire de_act = transceiver_enable_out ^ pol;
   int err_total = 0;
   int checked = 0;
   int cyc = 0;
   int de_falls = 0;
   int f0;
   int n;
   logic [31:0] rd;
   logic [11:0] fr;
   logic [7:0] c0;
   logic [7:0] c1;
   logic [7:0] d;
   // Control 0, control 1 and data byte of each ordinary row.
   logic [23:0] rows [7] = '{24'h0300A5, 24'h07003C, 24'h0F0001,
      24'h130080, 24'h1F01FF, 24'h07025A, 24'h0303C3};
   always #5 pclk = ~pclk;
   uart_de u_uart_de (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rxd_pin(rxd_pin), .txd_out(txd_out),
      .transceiver_enable_out(transceiver_enable_out),
      .tx_irq(tx_irq), .rx_irq(rx_irq));
   line_end #(.BIT(16)) u_line_end (.pclk(pclk), .txd(txd_out),
      .rxd(rxd_pin));
   // Counts enable drops to prove gapless back-to-back characters.
   always @(negedge de_act) de_falls++;
   // Cuts a hang short.
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         close_out();
      end
   end
   // Expected frame bits, start first, parity or stop after the data.
   function automatic logic [11:0] mk(input logic [7:0] v, c);
      mk = {2'b11, c[2] ? ^v ^ c[3] : 1'b1, v, 1'b0};
   endfunction
   task automatic chk(input logic [31:0] g, e);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask
   // One APB transfer; read data lands in rd.
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Waits a bounded time for one of the two requests.
   task automatic irqwait(input bit tx);
      int t;
      t = 0;
      while ((tx ? tx_irq : rx_irq) !== 1'b1 && t < 400) begin
         @(posedge pclk);
         t++;
      end
      chk(tx ? tx_irq : rx_irq, 1'b1);
   endtask
   task automatic close_out;
      if (err_total == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Ordinary rows, then back-to-back, address, parity, timer, reset.
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         {c0, c1, d} = rows[i];
         n = 10 + c0[2] + c0[4];
         apb(1'b1, 12'h00C, {24'h0, c0});
         apb(1'b1, 12'h010, {24'h0, c1});
         pol = c1[0];
         @(posedge pclk);
         chk(transceiver_enable_out, c1[0]);
         apb(1'b1, 12'h000, {24'h0, d});
         u_line_end.grab(n, fr);
         chk(fr, mk(d, c0));
         chk(de_act, 1'b1);
         repeat (20) @(posedge pclk);
         chk(de_act, 1'b0);
         chk({tx_irq, rx_irq}, 2'b10);
         u_line_end.send(mk(d, c0), n, c1[1]);
         irqwait(1'b0);
         apb(1'b0, 12'h008, 32'h0);
         chk(rd[1], 1'b0);
         apb(1'b0, 12'h004, 32'h0);
         chk(rd[7:0], d);
      end
      apb(1'b1, 12'h00C, 32'h3);
      apb(1'b1, 12'h010, 32'h0);
      pol = 1'b0;
      @(posedge pclk);
      f0 = de_falls;
      apb(1'b1, 12'h000, 32'h96);
      rd = 32'h0;
      for (int k = 0; k < 40 && rd[4] !== 1'b1; k++) begin
         apb(1'b0, 12'h008, 32'h0);
      end
      apb(1'b1, 12'h000, 32'h69);
      u_line_end.grab(10, fr);
      chk(fr, mk(8'h96, 8'h03));
      u_line_end.grab(10, fr);
      chk(fr, mk(8'h69, 8'h03));
      chk(de_falls - f0, 0);
      apb(1'b1, 12'h00C, 32'h7);
      apb(1'b1, 12'h010, 32'hC);
      u_line_end.send(12'hE24, 11, 1'b0);
      repeat (40) @(posedge pclk);
      chk(rx_irq, 1'b0);
      u_line_end.send(12'hC68, 11, 1'b0);
      irqwait(1'b0);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd[6], 1'b1);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd[7:0], 8'h34);
      apb(1'b1, 12'h000, 32'hA5);
      u_line_end.grab(11, fr);
      chk(fr, 12'hF4A);
      apb(1'b1, 12'h010, 32'h0);
      u_line_end.send(mk(8'h5B, 8'h07) ^ 12'h200, 11, 1'b0);
      irqwait(1'b0);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd[1], 1'b1);
      apb(1'b0, 12'h004, 32'h0);
      apb(1'b1, 12'h014, 32'h20);
      apb(1'b1, 12'h00C, 32'h0);
      @(posedge pclk);
      chk(tx_irq, 1'b0);
      irqwait(1'b1);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd[8], 1'b1);
      @(posedge pclk);
      chk(tx_irq, 1'b0);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      chk({txd_out, transceiver_enable_out, tx_irq, rx_irq}, 4'h8);
      presetn <= 1'b1;
      apb(1'b0, 12'h014, 32'h0);
      chk(rd, 32'h1);
      apb(1'b1, 12'h018, 32'hFFFF);
      apb(1'b0, 12'h018, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h00C, 32'h0);
      chk(rd, 32'h0);
      close_out();
   end
endmodule // uart_de_test
bind uart_de uart_de_asserts u_uart_de_asserts (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .txd_out(txd_out),
   .transceiver_enable_out(transceiver_enable_out), .rx_irq(rx_irq));
